// ### pin_board.sv
`timescale 1ns/1ps
module pin_board (
   input wire logic clk,
   input wire logic [23:0] pinOut,
   input wire logic [23:0] pinOe,
   input wire logic [23:0] pinPull,
   input wire logic [23:0] boardVal,
   input wire logic [23:0] boardDrive,
   output logic [23:0] pinsIn
);
   logic [23:0] floatLvl = 24'h000000;
   // ---------------------------------------------------------------
   // Pin resolution
   // ---------------------------------------------------------------
   // A pin nobody drives and nothing pulls wanders every cycle
   always @(posedge clk) begin
      floatLvl <= ~floatLvl;
   end
   assign pinsIn = (pinOe & pinOut) | (~pinOe & boardDrive & boardVal)
      | (~pinOe & ~boardDrive & (pinPull | floatLvl));
endmodule

// ### port_bcd_pin_override.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// - Port D pin 0 feeds interrupt source 0 when enabled, input kept enabled.
// - Compare-B enable makes pin D0 carry compare-B; output only if direction set.
// - Port D pins have override enable/value for pull, direction, value, input enable.
// - Transmitter forces D3 output, no pull, tx data; receiver forces D2 input.
// - Flow control drives D6 as request-to-send, D7 input; D5 drives serial clock in synchronous mode when its direction bit is set.
// - Global pull-up disable turns every port pull-up off.
// - Control register: bits 7,4,1,0 read-write, others read zero, reset zero.
// - Port B data register, 8 bits read-write at 0x05, reset zero.
// - Port B direction register, 8 bits at 0x04, reset zero, all inputs.
// - Port B input register at 0x03 returns pin levels.
// - Port C data at 0x08, bit 3 unimplemented, reads zero.
// - Port C direction at 0x07 omits bit 3; Port C pins at 0x06.
// - Port D data register, 8 bits read-write at 0x0B, reset zero.
// - Port D direction at 0x0A reset zero; Port D pins at 0x09.
// - Enabled transmitter makes its pin output regardless of direction bit.
// - Receiver-forced input pin keeps pull-up following its data bit.
// - In synchronous mode, clock pin direction bit selects clock out or in.
module port_bcd_pin_override (
   input wire logic clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [23:0] pinsIn,
   output logic [23:0] pinOut,
   output logic [23:0] pinOe,
   output logic [23:0] pinPull,
   input wire logic serialTxEnable,
   input wire logic serialTxLine,
   input wire logic serialRxEnable,
   input wire logic rtsFlowEnable,
   input wire logic rtsLevel,
   input wire logic ctsFlowEnable,
   input wire logic serialSyncMode,
   input wire logic serialSyncClockOut,
   input wire logic timerZeroCmpBEnable,
   input wire logic timerZeroCmpBOut,
   input wire logic [7:0] portDIrqEnable,
   input wire logic comparatorPosEnable,
   input wire logic comparatorNegEnable,
   output logic [7:0] portDAltIn,
   output logic extIrqSrcZero,
   output logic serialRxLine,
   output logic serialSyncClockIn,
   output logic timerZeroExtCount
);
   import port_bcd_pkg::*;

   typedef struct packed {
      logic readyOut;
      logic respErr;
      logic wrPend;
      logic [5:0] wrIdx;
      logic [7:0] dataB;
      logic [7:0] dirB;
      logic [7:0] dataC;
      logic [7:0] dirC;
      logic [7:0] dataD;
      logic [7:0] dirD;
      logic [7:0] mcuCtrl;
      logic [23:0] sync1;
      logic [23:0] sync2;
      logic [23:0] pinOut;
      logic [23:0] pinOe;
      logic [23:0] pinPull;
      logic [7:0] altIn;
      logic [31:0] rdata;
   } state_type;

   state_type st_ff;
   state_type nxt_st;

   // -----------------------------------------------------------------
   // Register read mux
   // -----------------------------------------------------------------
   function automatic logic [7:0] regRead(input logic [5:0] idx, input state_type s);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         IDX_LVLB: v = s.sync2[7:0];
         IDX_DIRB: v = s.dirB;
         IDX_DATAB: v = s.dataB;
         IDX_LVLC: v = s.sync2[15:8] & PORT_C_OUTPUT_DATA_MASK;
         IDX_DIRC: v = s.dirC;
         IDX_DATAC: v = s.dataC;
         IDX_LVLD: v = s.sync2[23:16];
         IDX_DIRD: v = s.dirD;
         IDX_DATAD: v = s.dataD;
         IDX_MCU: v = s.mcuCtrl;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [7:0] pullOvEn;
      logic [7:0] pullOvVal;
      logic [7:0] dirOvEn;
      logic [7:0] dirOvVal;
      logic [7:0] valOvEn;
      logic [7:0] valOvVal;
      logic [7:0] inOvEn;
      logic [7:0] inOvVal;
      logic [7:0] die;
      logic [23:0] dataAll;
      logic [23:0] dirAll;
      logic [23:0] pull;
      logic pullOff;
      pullOvEn = 8'h00;
      pullOvVal = 8'h00;
      dirOvEn = 8'h00;
      dirOvVal = 8'h00;
      valOvEn = 8'h00;
      valOvVal = 8'h00;
      inOvEn = 8'h00;
      inOvVal = 8'hff;
      die = 8'hff;
      dataAll = 24'h000000;
      dirAll = 24'h000000;
      pull = 24'h000000;
      pullOff = 1'b0;
      nxt_st = st_ff;
      nxt_st.readyOut = 1'b1;
      nxt_st.respErr = 1'b0;
      nxt_st.sync1 = pinsIn;
      nxt_st.sync2 = st_ff.sync1;

      // Data phase of a write
      if (st_ff.wrPend) begin
         case (st_ff.wrIdx)
            IDX_DIRB: nxt_st.dirB = hwdata[7:0];
            IDX_DATAB: nxt_st.dataB = hwdata[7:0];
            IDX_DIRC: nxt_st.dirC = hwdata[7:0] & PORT_C_OUTPUT_DATA_MASK;
            IDX_DATAC: nxt_st.dataC = hwdata[7:0] & PORT_C_OUTPUT_DATA_MASK;
            IDX_DIRD: nxt_st.dirD = hwdata[7:0];
            IDX_DATAD: nxt_st.dataD = hwdata[7:0];
            IDX_MCU: nxt_st.mcuCtrl = hwdata[7:0] & MCU_WR_MASK;
            default: ; // Pin registers and holes ignore writes
         endcase
      end

      // Address phase; read data sees a write finishing in this cycle
      nxt_st.wrPend = 1'b0;
      if (hsel && hready && htrans[1]) begin
         nxt_st.wrPend = hwrite;
         nxt_st.wrIdx = haddr[7:2];
         if (!hwrite) begin
            nxt_st.rdata = {24'h000000, regRead(haddr[7:2], nxt_st)};
         end
      end

      // Pin control from registers
      pullOff = nxt_st.mcuCtrl[PULL_OFF_BIT];
      dataAll = {nxt_st.dataD, nxt_st.dataC, nxt_st.dataB};
      dirAll = {nxt_st.dirD, nxt_st.dirC, nxt_st.dirB};
      pull = ~dirAll & dataAll & {24{~pullOff}};

      // Port D alternate-function overrides
      pullOvEn[PD_CTS] = ctsFlowEnable;
      pullOvVal[PD_CTS] = nxt_st.dataD[PD_CTS] & ~pullOff;
      dirOvEn[PD_CTS] = ctsFlowEnable;
      dirOvVal[PD_CTS] = 1'b0;
      inOvEn[PD_CTS] = portDIrqEnable[PD_CTS] | ctsFlowEnable;
      pullOvEn[PD_RTS] = rtsFlowEnable;
      pullOvVal[PD_RTS] = 1'b0;
      dirOvEn[PD_RTS] = rtsFlowEnable;
      dirOvVal[PD_RTS] = 1'b1;
      valOvEn[PD_RTS] = rtsFlowEnable;
      valOvVal[PD_RTS] = rtsLevel;
      inOvEn[PD_RTS] = portDIrqEnable[PD_RTS];
      valOvEn[PD_XCK] = serialSyncMode & nxt_st.dirD[PD_XCK];
      valOvVal[PD_XCK] = serialSyncClockOut;
      inOvEn[PD_XCK] = portDIrqEnable[PD_XCK] | serialSyncMode;
      inOvEn[4] = portDIrqEnable[4];
      pullOvEn[PD_TX] = serialTxEnable;
      pullOvVal[PD_TX] = 1'b0;
      dirOvEn[PD_TX] = serialTxEnable;
      dirOvVal[PD_TX] = 1'b1;
      valOvEn[PD_TX] = serialTxEnable;
      valOvVal[PD_TX] = serialTxLine;
      inOvEn[PD_TX] = portDIrqEnable[PD_TX];
      pullOvEn[PD_RX] = serialRxEnable;
      pullOvVal[PD_RX] = nxt_st.dataD[PD_RX] & ~pullOff;
      dirOvEn[PD_RX] = serialRxEnable;
      dirOvVal[PD_RX] = 1'b0;
      inOvEn[PD_RX] = portDIrqEnable[PD_RX] | comparatorNegEnable | serialRxEnable;
      inOvVal[PD_RX] = ~comparatorNegEnable;
      inOvEn[1] = portDIrqEnable[1] | comparatorPosEnable;
      inOvVal[1] = ~comparatorPosEnable;
      valOvEn[0] = timerZeroCmpBEnable;
      valOvVal[0] = timerZeroCmpBOut;
      inOvEn[0] = portDIrqEnable[0];

      for (int i = 0; i < 8; i++) begin
         if (pullOvEn[i]) begin
            pull[PD_BASE + i] = pullOvVal[i];
         end
         if (dirOvEn[i]) begin
            dirAll[PD_BASE + i] = dirOvVal[i];
         end
         if (valOvEn[i]) begin
            dataAll[PD_BASE + i] = valOvVal[i];
         end
         if (inOvEn[i]) begin
            die[i] = inOvVal[i];
         end
      end

      nxt_st.pinOut = dataAll;
      nxt_st.pinOe = dirAll;
      nxt_st.pinPull = pull;
      nxt_st.altIn = st_ff.sync2[23:16] & die;
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.readyOut <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign hreadyout = st_ff.readyOut;
   assign hresp = st_ff.respErr;
   assign hrdata = st_ff.rdata;
   assign pinOut = st_ff.pinOut;
   assign pinOe = st_ff.pinOe;
   assign pinPull = st_ff.pinPull;
   assign portDAltIn = st_ff.altIn;
   assign extIrqSrcZero = st_ff.altIn[0];
   assign serialRxLine = st_ff.altIn[PD_RX];
   assign serialSyncClockIn = st_ff.altIn[PD_XCK];
   assign timerZeroExtCount = st_ff.altIn[PD_CTS];

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_pull_off_all: assert property (st_ff.mcuCtrl[PULL_OFF_BIT] |-> st_ff.pinPull == 24'h000000)
      else $error("pull-up active while disabled");
   a_tx_forces_out: assert property (serialTxEnable |=> st_ff.pinOe[PD_BASE + PD_TX]
      && !st_ff.pinPull[PD_BASE + PD_TX] && st_ff.pinOut[PD_BASE + PD_TX] == $past(serialTxLine))
      else $error("transmit pin not driven");
   a_rx_forces_in: assert property (serialRxEnable |=> !st_ff.pinOe[PD_BASE + PD_RX]
      && st_ff.pinPull[PD_BASE + PD_RX] == (st_ff.dataD[PD_RX] & ~st_ff.mcuCtrl[PULL_OFF_BIT]))
      else $error("receive pin not input with data pull");
   a_rts_drives: assert property (rtsFlowEnable |=> st_ff.pinOe[PD_BASE + PD_RTS]
      && st_ff.pinOut[PD_BASE + PD_RTS] == $past(rtsLevel))
      else $error("request-to-send pin not driven");
   a_cts_input: assert property (ctsFlowEnable |=> !st_ff.pinOe[PD_BASE + PD_CTS])
      else $error("flow-control input pin driven");
   a_cmpb_drive: assert property (timerZeroCmpBEnable |=> st_ff.pinOut[PD_BASE] == $past(timerZeroCmpBOut)
      && st_ff.pinOe[PD_BASE] == st_ff.dirD[0])
      else $error("compare-B pin wrong");
   a_ext_irq_src_zero_sync: assert property (portDIrqEnable[0] ##1 portDIrqEnable[0]
      |=> extIrqSrcZero == $past(pinsIn[PD_BASE], 3))
      else $error("interrupt 0 input not synchronised level");
   a_port_c_output_data_bit3: assert property (st_ff.dataC[3] == 1'b0 && st_ff.dirC[3] == 1'b0)
      else $error("port C bit 3 set");
   a_dirb_write: assert property (st_ff.wrPend && st_ff.wrIdx == IDX_DIRB
      |=> st_ff.dirB == $past(hwdata[7:0]))
      else $error("direction B write lost");
   a_mcu_ro_zero: assert property ((st_ff.mcuCtrl & ~MCU_WR_MASK) == 8'h00)
      else $error("control register read-only bits set");

   c_tx_on: cover property (serialTxEnable ##1 st_ff.pinOe[PD_BASE + PD_TX]);
   c_pull_off_set: cover property (st_ff.wrPend && st_ff.wrIdx == IDX_MCU && hwdata[PULL_OFF_BIT]);
   c_read_lvld: cover property (hsel && hready && htrans[1] && !hwrite && haddr[7:2] == IDX_LVLD);

endmodule

// ### port_bcd_pkg.sv
package port_bcd_pkg;

   // -----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam logic [5:0] IDX_LVLB = 6'h03;
   localparam logic [5:0] IDX_DIRB = 6'h04;
   localparam logic [5:0] IDX_DATAB = 6'h05;
   localparam logic [5:0] IDX_LVLC = 6'h06;
   localparam logic [5:0] IDX_DIRC = 6'h07;
   localparam logic [5:0] IDX_DATAC = 6'h08;
   localparam logic [5:0] IDX_LVLD = 6'h09;
   localparam logic [5:0] IDX_DIRD = 6'h0a;
   localparam logic [5:0] IDX_DATAD = 6'h0b;
   localparam logic [5:0] IDX_MCU = 6'h35;

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] MCU_WR_MASK = 8'h93;
   localparam logic [7:0] PORT_C_OUTPUT_DATA_MASK = 8'hf7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int PULL_OFF_BIT = 4;
   localparam int PC_BASE = 8;
   localparam int PD_BASE = 16;
   localparam int PD_RX = 2;
   localparam int PD_TX = 3;
   localparam int PD_XCK = 5;
   localparam int PD_RTS = 6;
   localparam int PD_CTS = 7;

endpackage

// ### tb.sv
`timescale 1ns/1ps
module tb;
   import port_bcd_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic hready, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [23:0] pinsIn, pinOut, pinOe, pinPull;
   logic [23:0] bVal = 24'h0, bDrv = 24'h0;
   logic txEn = 0, txLine = 0, rxEn = 0, rtsEn = 0, rtsLvl = 0, ctsEn = 0;
   logic syncMode = 0, syncOut = 0, cmpEn = 0, cmpOut = 0, cPos = 0, cNeg = 0;
   logic [7:0] irqEn = 8'h0, altIn, rd;
   logic irq0, rxLine, syncIn, extCnt;
   int miscompares = 0, compares = 0, cyc = 0;
   logic [5:0] idx [7] = '{IDX_DIRB, IDX_DATAB, IDX_DIRC, IDX_DATAC, IDX_DIRD, IDX_DATAD,
      IDX_MCU};
   logic [7:0] msk [7] = '{8'hff, 8'hff, 8'hf7, 8'hf7, 8'hff, 8'hff, 8'h93};

   always #25 clk = ~clk;
   assign hready = hreadyout;

   port_bcd_pin_override port_bcd_pin_override_i (.clk(clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pinsIn(pinsIn), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull),
      .serialTxEnable(txEn), .serialTxLine(txLine), .serialRxEnable(rxEn),
      .rtsFlowEnable(rtsEn), .rtsLevel(rtsLvl), .ctsFlowEnable(ctsEn),
      .serialSyncMode(syncMode), .serialSyncClockOut(syncOut),
      .timerZeroCmpBEnable(cmpEn), .timerZeroCmpBOut(cmpOut), .portDIrqEnable(irqEn),
      .comparatorPosEnable(cPos), .comparatorNegEnable(cNeg), .portDAltIn(altIn),
      .extIrqSrcZero(irq0), .serialRxLine(rxLine), .serialSyncClockIn(syncIn),
      .timerZeroExtCount(extCnt));
   pin_board pin_board_i (.clk(clk), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull),
      .boardVal(bVal), .boardDrive(bDrv), .pinsIn(pinsIn));

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic bus(input logic wr, input logic [5:0] ix, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      hwrite <= wr;
      htrans <= 2'b10;
      haddr <= {24'h0, ix, 2'b00};
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask

   task automatic rdchk(input logic [5:0] ix, input logic [7:0] e);
      bus(1'b0, ix, 8'h00);
      chk("register", rd, e);
   endtask

   task automatic settle;
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic report_and_stop;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         report_and_stop();
      end
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         rdchk(idx[i], 8'h00);
         bus(1'b1, idx[i], 8'hff);
         rdchk(idx[i], msk[i]);
         bus(1'b1, idx[i], 8'h00);
      end
      bus(1'b1, 6'h20, 8'h5a);
      rdchk(6'h20, 8'h00);
      $display("test registers done");
      @(posedge clk);
      bVal <= 24'ha53c5a;
      bDrv <= 24'hffffff;
      settle();
      settle();
      rdchk(IDX_LVLB, 8'h5a);
      rdchk(IDX_LVLC, 8'h34);
      rdchk(IDX_LVLD, 8'ha5);
      bus(1'b1, IDX_LVLB, 8'h00);
      rdchk(IDX_LVLB, 8'h5a);
      chk("resp", hresp, 1'b0);
      rdchk(IDX_DATAB, 8'h00);
      $display("test pin levels done");
      bDrv <= 24'h0;
      bus(1'b1, IDX_DATAB, 8'hff);
      bus(1'b1, IDX_DATAC, 8'hff);
      bus(1'b1, IDX_DATAD, 8'hff);
      settle();
      chk("pull", pinPull, 24'hfff7ff);
      chk("oe", pinOe, 24'h0);
      bus(1'b1, IDX_MCU, 8'h10);
      settle();
      chk("pull", pinPull, 24'h0);
      bus(1'b1, IDX_MCU, 8'h00);
      $display("test pull-ups done");
      @(posedge clk);
      {txEn, txLine, rxEn, rtsEn, rtsLvl, ctsEn} <= 6'h3f;
      settle();
      chk("oe", pinOe[23:16], 8'h48);
      chk("out", pinOut[23:16] & 8'h48, 8'h48);
      chk("pull", pinPull[23:16], 8'hb7);
      txLine <= 1'b0;
      rtsLvl <= 1'b0;
      settle();
      chk("out", pinOut[23:16] & 8'h48, 8'h00);
      bus(1'b1, IDX_DIRD, 8'hff);
      settle();
      chk("oe", pinOe[23:16], 8'h7b);
      chk("pull", pinPull[23:16], 8'h84);
      bus(1'b1, IDX_MCU, 8'h10);
      settle();
      chk("pull", pinPull[23:16], 8'h00);
      bus(1'b1, IDX_MCU, 8'h00);
      {txEn, rxEn, rtsEn, ctsEn, cmpEn, cmpOut, syncMode, syncOut} <= 8'h0f;
      settle();
      chk("out", {pinOut[21], pinOut[16], pinOe[16]}, 3'h7);
      {cmpOut, syncOut} <= 2'b00;
      settle();
      chk("out", {pinOut[21], pinOut[16]}, 2'b00);
      bus(1'b1, IDX_DIRD, 8'h00);
      settle();
      chk("oe", {pinOe[21], pinOe[16]}, 2'b00);
      $display("test overrides done");
      @(posedge clk);
      bVal <= 24'ha20000;
      bDrv <= 24'hff0000;
      irqEn <= 8'h01;
      cPos <= 1'b1;
      repeat (4) settle();
      bVal <= 24'ha30000;
      settle();
      chk("irq", irq0, 1'b0);
      settle();
      settle();
      chk("irq", irq0, 1'b1);
      chk("clkin", syncIn, 1'b1);
      chk("altin", altIn[1:0], 2'b01);
      chk("rxline", rxLine, 1'b0);
      chk("extcnt", extCnt, 1'b1);
      $display("test inputs done");
      report_and_stop();
   end
endmodule
